//--- logic/acts_sar_step.sv
// Successive approximation register: one trial bit per step, MSB first.
// Assumes the comparator answer is valid when step is pulsed.
`timescale 1ns/1ps
module acts_sar_step (
   input  wire logic       core_clk,
   input  wire logic       arst_n,
   input  wire logic       clear,
   input  wire logic       step,
   input  wire logic       comp_high,
   output logic [9:0]      trial_code
);

   logic [9:0] code;
   logic [3:0] idx;
   logic [9:0] next_code;
   logic [3:0] next_idx;
   logic [9:0] mask;

   assign trial_code = code;

   // Keep the trial bit if the held input is at or above the trial level
   always_comb begin
      mask      = 10'(10'h001 << idx);
      next_code = code;
      next_idx  = idx;
      if (clear) begin
         next_code = acts_pkg::SAR_START_CODE;
         next_idx  = acts_pkg::SAR_TOP_BIT;
      end else if (step) begin
         next_code = comp_high ? code : (code & ~mask);
         if (idx != 4'h0) begin
            next_code = next_code | 10'(mask >> 1); // Next trial bit
            next_idx  = idx - 4'h1;
         end
      end
   end

   // Registers only
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         code <= 10'h000;
         idx  <= 4'h0;
      end else begin
         code <= next_code;
         idx  <= next_idx;
      end
   end

endmodule

//--- logic/acts_sequencer.sv
// Timing sequencer for one 10-bit successive approximation conversion.
// Assumes the analog front end tracks while sample_switch_on is high and
// holds otherwise, and that comp_high compares the held value with dac_code.
//
// Behaviour
// - Each start taken in idle with power on samples the input, then resolves ten successive approximation steps.
// - Sample and comparison lengths are programmed and counted on the CPU clock.
// - Conversion-time and sample-time fields sit in control bits fifteen to twelve.
// - All phase lengths are given in half CPU clock period units and counted in whole CPU clock cycles.
// - Time code 00 gives the fast table of sample, compare, extra lengths.
// - Time code 11 gives doubled sample and compare lengths; the extra lengths have their own values.
// - Time code 10 gives quadrupled sample and compare lengths; the extra lengths have their own values.
// - A conversion is sample, then comparison, then extra transfer phase.
// - After sampling the held value is used; input changes no longer matter.
// - Inputs below ground give 0x000, above reference give 0x3FF.
// - Result steps by one LSB, reference divided by 1024.
// - Power-off bit switches the converter circuitry off.
`timescale 1ns/1ps
module acts_sequencer (
   input  wire logic        core_clk,
   input  wire logic        arst_n,
   input  wire logic [15:0] converter_control_reg,
   input  wire logic        converter_power_off,
   input  wire logic        conv_start,
   input  wire logic        comp_high,
   output logic             analog_enable,
   output logic             sample_switch_on,
   output logic [9:0]       dac_code,
   output logic             conv_busy,
   output logic [1:0]       phase_code,
   output logic [9:0]       conv_result,
   output logic             conv_done,
   output logic             reserved_code_seen
);

   // Timing fields pulled from the control word
   logic [1:0]                   conv_time_select;
   logic [1:0]                   sample_time_select;
   acts_pkg::acts_phase_type     start_units;

   // Sequencer state
   acts_pkg::acts_state_type     state;
   acts_pkg::acts_state_type     next_state;
   logic [acts_pkg::CNT_W-1:0]   cnt;
   logic [acts_pkg::CNT_W-1:0]   next_cnt;
   logic [3:0]                   step_num;
   logic [3:0]                   next_step_num;

   // Phase lengths latched at start, in cycles
   logic [acts_pkg::CNT_W-1:0]   step_len;
   logic [acts_pkg::CNT_W-1:0]   next_step_len;
   logic [acts_pkg::CNT_W-1:0]   extra_len;
   logic [acts_pkg::CNT_W-1:0]   next_extra_len;

   // Outputs held in flip-flops
   logic [9:0]                   result;
   logic [9:0]                   next_result;
   logic                         done;
   logic                         next_done;
   logic                         reserved;
   logic                         next_reserved;
   logic                         power_on;
   logic                         next_power_on;

   // Strobes to the approximation register
   logic                         sar_clear;
   logic                         sar_step;
   logic [9:0]                   sar_code;

   // Field extraction from the upper four control bits
   assign conv_time_select   = converter_control_reg[acts_pkg::CTRL_CT_LSB +: 2];
   assign sample_time_select = converter_control_reg[acts_pkg::CTRL_ST_LSB +: 2];

   // Table lookup; the reserved code maps onto the fast row
   assign start_units = acts_pkg::acts_units(conv_time_select,
                                             sample_time_select);

   // Port drives
   assign analog_enable      = power_on;
   assign sample_switch_on   = (state == acts_pkg::ACTS_SAMPLE);
   assign dac_code           = sar_code;
   assign conv_busy          = (state != acts_pkg::ACTS_IDLE);
   assign phase_code         = state;
   assign conv_result        = result;
   assign conv_done          = done;
   assign reserved_code_seen = reserved;

   // Approximation register; saturation falls out of the search itself,
   // since a comparator stuck low or high yields all zeros or all ones
   acts_sar_step u_sar (
      .core_clk   (core_clk),
      .arst_n     (arst_n),
      .clear      (sar_clear),
      .step       (sar_step),
      .comp_high  (comp_high),
      .trial_code (sar_code)
   );

   // Power control follows the off bit with one register stage
   always_comb begin
      next_power_on = ~converter_power_off;
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         power_on <= 1'b0;
      end else begin
         power_on <= next_power_on;
      end
   end

   // Phase sequencing; lengths are latched at start so a control write
   // during a conversion cannot stretch or cut the running phase
   always_comb begin
      next_state     = state;
      next_cnt       = cnt;
      next_step_num  = step_num;
      next_step_len  = step_len;
      next_extra_len = extra_len;
      next_result    = result;
      next_done      = 1'b0;
      next_reserved  = reserved;
      sar_clear      = 1'b0;
      sar_step       = 1'b0;
      if (converter_power_off) begin
         // Circuitry off: any conversion is dropped without a result
         next_state = acts_pkg::ACTS_IDLE;
         next_cnt   = acts_pkg::CNT_ZERO;
      end else begin
         unique case (state)
            acts_pkg::ACTS_IDLE: begin
               if (conv_start) begin
                  // Half-period units to cycles; the comparison window is
                  // split evenly across the ten trial bits
                  next_state     = acts_pkg::ACTS_SAMPLE;
                  next_cnt       = acts_pkg::acts_cycles(start_units.sample)
                                   - acts_pkg::CNT_ONE;
                  next_step_len  = 11'(acts_pkg::acts_cycles(start_units.compare)
                                   / acts_pkg::RES_BITS);
                  next_extra_len = acts_pkg::acts_cycles(start_units.extra);
                  next_step_num  = 4'h0;
                  next_reserved  = (conv_time_select == acts_pkg::CT_RSVD);
                  sar_clear      = 1'b1;
               end
            end
            acts_pkg::ACTS_SAMPLE: begin
               if (cnt == acts_pkg::CNT_ZERO) begin
                  // Switch opens here; the held level feeds every step
                  next_state = acts_pkg::ACTS_COMPARE;
                  next_cnt   = step_len - acts_pkg::CNT_ONE;
               end else begin
                  next_cnt = cnt - acts_pkg::CNT_ONE;
               end
            end
            acts_pkg::ACTS_COMPARE: begin
               if (cnt == acts_pkg::CNT_ZERO) begin
                  // Decide the current bit at the end of its window
                  sar_step = 1'b1;
                  if (step_num == acts_pkg::LAST_STEP) begin
                     next_state = acts_pkg::ACTS_EXTRA;
                     next_cnt   = extra_len - acts_pkg::CNT_ONE;
                  end else begin
                     next_step_num = step_num + 4'h1;
                     next_cnt      = step_len - acts_pkg::CNT_ONE;
                  end
               end else begin
                  next_cnt = cnt - acts_pkg::CNT_ONE;
               end
            end
            acts_pkg::ACTS_EXTRA: begin
               if (cnt == acts_pkg::CNT_ZERO) begin
                  next_state  = acts_pkg::ACTS_IDLE;
                  next_result = sar_code;
                  next_done   = 1'b1;
               end else begin
                  next_cnt = cnt - acts_pkg::CNT_ONE;
               end
            end
         endcase
      end
   end

   // Sequencer registers only
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         state     <= acts_pkg::ACTS_IDLE;
         cnt       <= acts_pkg::CNT_ZERO;
         step_num  <= 4'h0;
         step_len  <= acts_pkg::CNT_ZERO;
         extra_len <= acts_pkg::CNT_ZERO;
         result    <= acts_pkg::RESULT_MIN;
         done      <= 1'b0;
         reserved  <= 1'b0;
      end else begin
         state     <= next_state;
         cnt       <= next_cnt;
         step_num  <= next_step_num;
         step_len  <= next_step_len;
         extra_len <= next_extra_len;
         result    <= next_result;
         done      <= next_done;
         reserved  <= next_reserved;
      end
   end

endmodule

//--- pkg/acts_pkg.sv
// Constants and phase table for the conversion timing sequencer.
// Assumes one 125 MHz core clock that also serves as the CPU clock.
package acts_pkg;

   // Result resolution and the codes that bound it
   localparam int unsigned RES_BITS        = 10;
   localparam logic [9:0]  RESULT_MIN      = 10'h000;
   localparam logic [9:0]  RESULT_MAX      = 10'h3FF;
   localparam logic [9:0]  SAR_START_CODE  = 10'h200;
   localparam logic [3:0]  SAR_TOP_BIT     = 4'h9;
   localparam logic [3:0]  LAST_STEP       = 4'h9;

   // Control word layout: timing fields in the upper four bits
   localparam int unsigned CTRL_W          = 16;
   localparam int unsigned CTRL_CT_LSB     = 14;
   localparam int unsigned CTRL_ST_LSB     = 12;

   // Conversion-time codes; code 01 is reserved
   localparam logic [1:0]  CT_FAST         = 2'h0;
   localparam logic [1:0]  CT_RSVD         = 2'h1;
   localparam logic [1:0]  CT_SLOW         = 2'h2;
   localparam logic [1:0]  CT_MID          = 2'h3;

   // Clock and unit: one unit is half a CPU clock period
   localparam int unsigned CLK_PERIOD_PS   = 8000;
   localparam int unsigned UNIT_PS         = CLK_PERIOD_PS / 2;
   localparam int unsigned UNITS_PER_CYCLE = CLK_PERIOD_PS / UNIT_PS;

   // Counter width covers the longest phase in cycles
   localparam int unsigned CNT_W           = 11;
   localparam logic [10:0] CNT_ZERO        = 11'h000;
   localparam logic [10:0] CNT_ONE         = 11'h001;

   // Phase lengths in half-period units
   typedef struct packed {
      logic [10:0] sample;
      logic [10:0] compare;
      logic [10:0] extra;
   } acts_phase_type;

   // Sequencer states
   typedef enum logic [1:0] {
      ACTS_IDLE    = 2'b00,
      ACTS_SAMPLE  = 2'b01,
      ACTS_COMPARE = 2'b10,
      ACTS_EXTRA   = 2'b11
   } acts_state_type;

   // Reserved conversion-time code falls back to the fast timing
   function automatic logic [1:0] acts_eff_ct(input logic [1:0] ct);
      acts_eff_ct = (ct == CT_RSVD) ? CT_FAST : ct;
   endfunction

   // Phase table in units, indexed by effective time code and sample code
   function automatic acts_phase_type acts_units(input logic [1:0] ct, input logic [1:0] st);
      acts_phase_type p;
      p = '{11'h078, 11'h0F0, 11'h01C};
      unique case ({acts_eff_ct(ct), st})
         4'h0: p = '{11'h078, 11'h0F0, 11'h01C};
         4'h1: p = '{11'h08C, 11'h118, 11'h010};
         4'h2: p = '{11'h0C8, 11'h118, 11'h034};
         4'h3: p = '{11'h190, 11'h118, 11'h02C};
         4'hC: p = '{11'h0F0, 11'h1E0, 11'h034};
         4'hD: p = '{11'h118, 11'h230, 11'h01C};
         4'hE: p = '{11'h190, 11'h230, 11'h064};
         4'hF: p = '{11'h320, 11'h230, 11'h034};
         4'h8: p = '{11'h1E0, 11'h3C0, 11'h064};
         4'h9: p = '{11'h230, 11'h460, 11'h034};
         4'hA: p = '{11'h320, 11'h460, 11'h0C4};
         4'hB: p = '{11'h640, 11'h460, 11'h0A4};
         default: p = '{11'h078, 11'h0F0, 11'h01C};
      endcase
      acts_units = p;
   endfunction

   // Units to whole clock cycles
   function automatic logic [10:0] acts_cycles(input logic [10:0] units);
      acts_cycles = 11'(units / UNITS_PER_CYCLE);
   endfunction

endpackage

//--- testbench/acts_analog_model.sv
// Analog front end model: sample capacitor and comparator.
// Assumes input and reference in millivolts.
`timescale 1ns/1ps
module acts_analog_model #(
   parameter int VREF_MV = 5000
) (
   input  wire logic               core_clk,
   input  wire logic               analog_enable,
   input  wire logic               sample_switch_on,
   input  wire logic [9:0]         dac_code,
   input  wire logic signed [15:0] vin_mv,
   output logic                    comp_high
);
   int   held_mv = 0;
   logic tog = 1'b0;
   // Capacitor follows the pin only while the switch is closed
   always @(posedge core_clk) begin
      if (sample_switch_on)
         held_mv <= vin_mv;
      tog <= ~tog;
   end
   // Ideal compare on the LSB grid, rails saturate; off gives noise
   assign comp_high = analog_enable ? (held_mv * 1024 >= int'(dac_code) * VREF_MV) : tog;
endmodule

//--- testbench/acts_sequencer_props.sv
// Checker for the conversion timing sequencer.
// Sees only the ports of acts_sequencer; bound below.
`timescale 1ns/1ps
module acts_sequencer_props (
   input wire logic        core_clk,
   input wire logic        arst_n,
   input wire logic [15:0] converter_control_reg,
   input wire logic        converter_power_off,
   input wire logic        conv_start,
   input wire logic        comp_high,
   input wire logic        analog_enable,
   input wire logic        sample_switch_on,
   input wire logic [9:0]  dac_code,
   input wire logic        conv_busy,
   input wire logic [1:0]  phase_code,
   input wire logic [9:0]  conv_result,
   input wire logic        conv_done,
   input wire logic        reserved_code_seen
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!arst_n);
   // Start taken in idle with power on
   sequence s_take;
      phase_code == 2'h0 && conv_start && !converter_power_off;
   endsequence
   // Last extra cycle before the result lands; a power cut there ends with no result
   sequence s_finish;
      phase_code == 2'h3 && !converter_power_off ##1 phase_code == 2'h0;
   endsequence
   property p_take;
      s_take |=> phase_code == 2'h1 && dac_code == 10'h200;
   endproperty
   a_take: assert property (p_take) else $error("start not taken");
   property p_rsvd;
      s_take ##0 converter_control_reg[15:14] == 2'h1 |=> reserved_code_seen;
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved code missed");
   property p_switch;
      sample_switch_on == (phase_code == 2'h1) && conv_busy == (phase_code != 2'h0);
   endproperty
   a_switch: assert property (p_switch) else $error("switch or busy off phase");
   property p_order;
      phase_code != 2'h0 && !converter_power_off |=>
         phase_code == $past(phase_code) || phase_code == $past(phase_code) + 2'h1;
   endproperty
   a_order: assert property (p_order) else $error("phase order broken");
   property p_done_src;
      conv_done |-> $past(phase_code) == 2'h3 && phase_code == 2'h0;
   endproperty
   a_done_src: assert property (p_done_src) else $error("done without extra");
   property p_pulse;
      conv_done |=> !conv_done;
   endproperty
   a_pulse: assert property (p_pulse) else $error("done longer than one cycle");
   property p_hold_res;
      !conv_done |-> $stable(conv_result);
   endproperty
   a_hold_res: assert property (p_hold_res) else $error("result moved without done");
   property p_off;
      converter_power_off |=> phase_code == 2'h0 && !conv_done && !analog_enable;
   endproperty
   a_off: assert property (p_off) else $error("power off not obeyed");
   property p_finish;
      s_finish |-> conv_done;
   endproperty
   a_finish: assert property (p_finish) else $error("extra end without done");
endmodule

bind acts_sequencer acts_sequencer_props i_acts_sequencer_props (
   .core_clk(core_clk), .arst_n(arst_n), .converter_control_reg(converter_control_reg),
   .converter_power_off(converter_power_off), .conv_start(conv_start),
   .comp_high(comp_high), .analog_enable(analog_enable), .sample_switch_on(sample_switch_on),
   .dac_code(dac_code), .conv_busy(conv_busy), .phase_code(phase_code),
   .conv_result(conv_result), .conv_done(conv_done), .reserved_code_seen(reserved_code_seen));

//--- testbench/acts_sequencer_test.sv
// Self-checking bench for the conversion timing sequencer.
// Assumes the analog model answers the comparator.
`timescale 1ns/1ps
`define CHK(name, exp, got) begin \
   checks_done++; \
   if ((got) !== (exp)) begin \
      errors++; \
      $display("MISMATCH %s expected %0h seen %0h", name, exp, got); \
   end \
end
module acts_sequencer_test;
   logic               core_clk;
   logic               arst_n;
   logic [15:0]        converter_control_reg;
   logic               converter_power_off;
   logic               conv_start;
   logic               comp_high;
   logic               analog_enable;
   logic               sample_switch_on;
   logic [9:0]         dac_code;
   logic               conv_busy;
   logic [1:0]         phase_code;
   logic [9:0]         conv_result;
   logic               conv_done;
   logic               reserved_code_seen;
   logic signed [15:0] vin_mv;
   int                 errors = 0;
   int                 checks_done = 0;
   // Phase units by {time code, sample code}; code 01 mirrors 00
   int su[16] = '{120, 140, 200, 400, 120, 140, 200, 400, 480, 560, 800, 1600,
                  240, 280, 400, 800};
   int cu[16] = '{240, 280, 280, 280, 240, 280, 280, 280, 960, 1120, 1120, 1120,
                  480, 560, 560, 560};
   int eu[16] = '{28, 16, 52, 44, 28, 16, 52, 44, 100, 52, 196, 164, 52, 28, 100, 52};

   acts_sequencer i_acts_sequencer (
      .core_clk(core_clk), .arst_n(arst_n), .converter_control_reg(converter_control_reg),
      .converter_power_off(converter_power_off), .conv_start(conv_start),
      .comp_high(comp_high), .analog_enable(analog_enable),
      .sample_switch_on(sample_switch_on), .dac_code(dac_code), .conv_busy(conv_busy),
      .phase_code(phase_code), .conv_result(conv_result), .conv_done(conv_done),
      .reserved_code_seen(reserved_code_seen));
   acts_analog_model i_acts_analog_model (
      .core_clk(core_clk), .analog_enable(analog_enable),
      .sample_switch_on(sample_switch_on), .dac_code(dac_code), .vin_mv(vin_mv),
      .comp_high(comp_high));

   // 125 MHz clock
   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end

   // Prints counts and verdict, ends the run
   task automatic results();
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // One conversion; start held two extra busy cycles, input moved after sampling
   task automatic run_conv(input logic [3:0] code, input int vin, input int vlate,
                           input logic [9:0] exp);
      int   n;
      int   s;
      int   c;
      int   b;
      logic late;
      logic fin;
      n = 0;
      s = 0;
      c = 0;
      b = 0;
      late = 1'b0;
      fin = 1'b0;
      @(posedge core_clk);
      converter_control_reg <= {code, 12'h000};
      vin_mv <= 16'(vin);
      conv_start <= 1'b1;
      // Drive on the edge, look 1 ns later once the outputs have settled
      while (n < 3000 && !fin) begin
         @(posedge core_clk);
         if (n == 2)
            conv_start <= 1'b0;
         if (late)
            vin_mv <= 16'(vlate);
         #1;
         n++;
         if (sample_switch_on === 1'b1)
            s++;
         if (phase_code === 2'h2) begin
            c++;
            late = 1'b1;
         end
         if (conv_busy === 1'b1)
            b++;
         fin = (conv_done === 1'b1);
      end
      `CHK("total", (su[code] + cu[code] + eu[code]) / 2 + 1, n)
      `CHK("sample", su[code] / 2, s)
      `CHK("compare", cu[code] / 2, c)
      `CHK("busy", (su[code] + cu[code] + eu[code]) / 2, b)
      `CHK("result", exp, conv_result)
      `CHK("reserved", code[3:2] == 2'h1, reserved_code_seen)
      @(posedge core_clk);
      #1;
      `CHK("done_drop", 1'b0, conv_done)
   endtask

   // Power off mid-conversion with start held: abort, no done, result kept
   task automatic power_cut();
      logic [9:0] keep;
      int         d;
      d = 0;
      @(posedge core_clk);
      keep = conv_result;
      converter_control_reg <= 16'h0000;
      vin_mv <= 16'sd1000;
      conv_start <= 1'b1;
      repeat (100) @(posedge core_clk);
      converter_power_off <= 1'b1;
      repeat (250) begin
         @(posedge core_clk);
         #1;
         if (conv_done !== 1'b0)
            d++;
      end
      `CHK("off_phase", 2'h0, phase_code)
      `CHK("off_enable", 1'b0, analog_enable)
      `CHK("off_done", 0, d)
      `CHK("off_result", keep, conv_result)
      @(posedge core_clk);
      conv_start <= 1'b0;
      converter_power_off <= 1'b0;
      repeat (2) @(posedge core_clk);
      #1;
      `CHK("on_enable", 1'b1, analog_enable)
   endtask

   // Main sequence
   initial begin
      arst_n = 1'b0;
      converter_control_reg = 16'h0000;
      converter_power_off = 1'b0;
      conv_start = 1'b0;
      vin_mv = 16'sd0;
      repeat (5) @(posedge core_clk);
      arst_n <= 1'b1;
      @(posedge core_clk);
      for (int i = 0; i < 16; i++)
         run_conv(4'(i), 100 + i * 300, 4900, 10'((100 + i * 300) * 1024 / 5000));
      run_conv(4'h0, -100, 2500, 10'h000);
      run_conv(4'h0, 5200, 0, 10'h3FF);
      power_cut();
      results();
   end

   // Watchdog well past the expected nine thousand cycles
   initial begin
      repeat (20000) @(posedge core_clk);
      errors++;
      results();
   end
endmodule
